// *** dcsf_pkg.sv ***
package dcsf_pkg;

  localparam int          NCH        = 8;
  localparam int          GRP        = 4;
  localparam logic [31:0] BASE_ADDR  = 32'h5008_1000;
  localparam logic [11:0] OFS_STATUS = 12'h000;
  localparam logic [11:0] OFS_CLEAR  = 12'h004;
  localparam logic [11:0] OFS_MASK   = 12'h040;
  localparam logic [11:0] OFS_EVENT  = 12'h044;
  localparam logic [11:0] OFS_NONE   = 12'hffc;

  localparam int          BIT_ERR    = 3;
  localparam int          BIT_HALF   = 2;
  localparam int          BIT_DONE   = 1;
  localparam int          BIT_GLOB   = 0;

  localparam logic [31:0] RST_FLAGS  = 32'h0000_0000;
  localparam logic [31:0] RST_MASK   = 32'h0000_0000;
  localparam logic [31:0] RST_EVENT  = 32'h0000_0000;

  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] mask;
    logic [31:0] evt;
    logic [31:0] rdata;
    logic [11:0] dp_ofs;
    logic        dp_wr;
    logic        rdy;
    logic        irq;
    logic [7:0]  chan_irq;
    logic [7:0]  trig;
  } dcsf_state_t;

  localparam dcsf_state_t RST_STATE = '{
    flags:    RST_FLAGS,
    mask:     RST_MASK,
    evt:      RST_EVENT,
    rdata:    32'h0000_0000,
    dp_ofs:   OFS_NONE,
    dp_wr:    1'h0,
    rdy:      1'h1,
    irq:      1'h0,
    chan_irq: 8'h00,
    trig:     8'h00
  };

endpackage

// *** dcsf_top.sv ***
`timescale 1ns/1ns
module dcsf_top (
  input  wire  logic                            sys_clk,
  input  wire  logic                            rstn,
  input  wire  logic                            hsel,
  input  wire  logic [31:0]                     haddr,
  input  wire  logic [1:0]                      htrans,
  input  wire  logic                            hwrite,
  input  wire  logic [2:0]                      hsize,
  input  wire  logic [31:0]                     hwdata,
  input  wire  logic                            hready,
  output logic       [31:0]                     hrdata,
  output logic                                  hreadyout,
  output logic                                  hresp,
  input  wire  logic [dcsf_pkg::NCH-1:0]        err_evt,
  input  wire  logic [dcsf_pkg::NCH-1:0]        half_evt,
  input  wire  logic [dcsf_pkg::NCH-1:0]        done_evt,
  output logic       [dcsf_pkg::NCH-1:0]        chan_irq,
  output logic       [dcsf_pkg::NCH-1:0]        chan_trig,
  output logic                                  irq
);
  import dcsf_pkg::*;

  dcsf_state_t s;
  dcsf_state_t next_s;

  logic [31:0] set_v;
  logic [31:0] clr_word;
  logic [31:0] clr_v;
  logic [31:0] evt_v;
  logic [7:0]  glob_ok;
  logic        take;
  logic        hit;

  // Address phase is taken only when the bus is ready; hsize is ignored
  // because only whole-word transfers reach this slave.
  assign take = hsel && htrans[1] && hready;
  assign hit  = (haddr[31:12] == BASE_ADDR[31:12]);

  // Clear bits only count during the data phase of a write to the clear word
  assign clr_word = (s.dp_wr && s.dp_ofs == OFS_CLEAR) ? hwdata : 32'h0000_0000;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign set_v[GRP*c+BIT_ERR]  = err_evt[c];
      assign set_v[GRP*c+BIT_HALF] = half_evt[c];
      assign set_v[GRP*c+BIT_DONE] = done_evt[c];
      assign set_v[GRP*c+BIT_GLOB] = 1'b0;
      assign clr_v[GRP*c+BIT_ERR]  = clr_word[GRP*c+BIT_ERR] | clr_word[GRP*c+BIT_GLOB];
      assign clr_v[GRP*c+BIT_HALF] = clr_word[GRP*c+BIT_HALF] | clr_word[GRP*c+BIT_GLOB];
      assign clr_v[GRP*c+BIT_DONE] = clr_word[GRP*c+BIT_DONE] | clr_word[GRP*c+BIT_GLOB];
      assign clr_v[GRP*c+BIT_GLOB] = 1'b0;
      assign evt_v[GRP*c+3:GRP*c+1] = set_v[GRP*c+3:GRP*c+1];
      assign evt_v[GRP*c+BIT_GLOB]  = |set_v[GRP*c+3:GRP*c+1];
      assign glob_ok[c] = (s.flags[GRP*c+BIT_GLOB] == |s.flags[GRP*c+3:GRP*c+1]);
    end
  endgenerate

  always_comb begin
    logic [31:0] fl;
    logic        rd_evt;
    fl     = 32'h0000_0000;
    rd_evt = 1'b0;
    next_s = s;
    next_s.rdy = 1'b1;

    // Set wins over a clear in the same cycle
    fl = set_v | (s.flags & ~clr_v);
    for (int i = 0; i < NCH; i++) begin
      fl[GRP*i+BIT_GLOB] = |fl[GRP*i+1 +: 3];
    end
    next_s.flags = fl;

    // Writes to status match no branch here and are dropped
    if (s.dp_wr && s.dp_ofs == OFS_MASK) begin
      next_s.mask = hwdata;
    end

    next_s.dp_wr  = take && hwrite;
    next_s.dp_ofs = (take && hit) ? haddr[11:0] : OFS_NONE;
    next_s.rdata  = 32'h0000_0000;
    // Status and mask read data come from the next state so a read that directly
    // follows a write already sees the write's effect; event reads return s.evt.
    if (take && !hwrite && hit) begin
      case (haddr[11:0])
        OFS_STATUS: next_s.rdata = fl;
        OFS_MASK:   next_s.rdata = next_s.mask;
        OFS_EVENT: begin
          next_s.rdata = s.evt;
          rd_evt       = 1'b1;
        end
        default:    next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Sticky event bits clear on read, a new event in the same cycle survives
    next_s.evt = evt_v | (rd_evt ? 32'h0000_0000 : s.evt);
    next_s.irq = |(next_s.evt & next_s.mask);

    for (int i = 0; i < NCH; i++) begin
      next_s.chan_irq[i] = |(fl[GRP*i+1 +: 3] & next_s.mask[GRP*i+1 +: 3]);
      next_s.trig[i]     = evt_v[GRP*i+BIT_GLOB];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s <= RST_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata    = s.rdata;
  assign hreadyout = s.rdy;
  assign hresp     = 1'b0;
  assign chan_irq  = s.chan_irq;
  assign chan_trig = s.trig;
  assign irq       = s.irq;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  reset_zero_a: assert property (
    disable iff (1'b0)
    !rstn |=> (s.flags == 32'h0000_0000) && !irq && (chan_irq == 8'h00)
  ) else $error("flags not zero after reset");

  status_read_a: assert property (
    take && !hwrite && (haddr == BASE_ADDR + {20'h00000, OFS_STATUS})
    |=> hrdata == s.flags
  ) else $error("status read does not show flags");

  miss_read_a: assert property (
    take && !hwrite && !hit
    |=> hrdata == 32'h0000_0000
  ) else $error("unmapped read not zero");

  err_set_a: assert property (
    err_evt[0] |=> s.flags[BIT_ERR] && s.flags[BIT_GLOB] ##1 s.flags[BIT_ERR] || $past(clr_v[BIT_ERR])
  ) else $error("error flag not set by event");

  set_wins_a: assert property (
    set_v != 32'h0000_0000
    |=> (s.flags & $past(set_v)) == $past(set_v)
  ) else $error("event lost against clear");

  half_hold_a: assert property (
    s.flags[BIT_HALF] && !half_evt[0] && !clr_v[BIT_HALF]
    |=> s.flags[BIT_HALF]
  ) else $error("half flag dropped without clear");

  clear_bits_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_CLEAR && set_v == 32'h0000_0000
    |=> (s.flags & $past(clr_v)) == 32'h0000_0000
  ) else $error("clear write left a flag set");

  glob_clear_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_CLEAR && hwdata[BIT_GLOB] && set_v[3:0] == 4'h0
    |=> s.flags[3:0] == 4'h0
  ) else $error("global clear missed a flag");

  done_clear_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_CLEAR && hwdata[BIT_DONE] && !done_evt[0]
    |=> !s.flags[BIT_DONE]
  ) else $error("complete clear ignored");

  global_flag_a: assert property (
    glob_ok == 8'hff
  ) else $error("global flag out of step");

  status_ro_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_STATUS && set_v == 32'h0000_0000
    |=> $stable(s.flags)
  ) else $error("write changed status");

  zero_clear_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_CLEAR && hwdata == 32'h0000_0000 && set_v == 32'h0000_0000
    |=> $stable(s.flags)
  ) else $error("zero clear changed status");

  clear_reads_a: assert property (
    take && !hwrite && hit && haddr[11:0] == OFS_CLEAR
    |=> hrdata == 32'h0000_0000
  ) else $error("clear word read not zero");

  trig_pulse_a: assert property (
    (err_evt[0] || half_evt[0] || done_evt[0])
    |=> chan_trig[0]
  ) else $error("trigger missing after event");

  chan_irq_a: assert property (
    chan_irq[0] == |(s.flags[3:1] & s.mask[3:1])
  ) else $error("channel interrupt out of step");

  irq_level_a: assert property (
    irq == |(s.evt & s.mask)
  ) else $error("interrupt output out of step");

  ready_high_a: assert property (
    hreadyout && !hresp
  ) else $error("slave inserted a wait or an error");

  idle_rdata_a: assert property (
    !(take && !hwrite && hit)
    |=> hrdata == 32'h0000_0000
  ) else $error("read data outside a read data phase");

  mask_write_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_MASK
    |=> s.mask == $past(hwdata)
  ) else $error("mask write not stored");

  event_read_a: assert property (
    take && !hwrite && hit && haddr[11:0] == OFS_EVENT
    |=> (hrdata == $past(s.evt)) && (s.evt == $past(evt_v))
  ) else $error("event status read or clear wrong");

  event_sticky_a: assert property (
    !(take && !hwrite && hit && haddr[11:0] == OFS_EVENT)
    |=> (s.evt & $past(s.evt)) == $past(s.evt)
  ) else $error("event status bit lost without read");

  miss_write_a: assert property (
    s.dp_wr && s.dp_ofs == OFS_NONE && set_v == 32'h0000_0000
    |=> $stable(s.flags) && $stable(s.mask)
  ) else $error("unmapped write changed state");

  // Per-channel checks: a slip in the group arithmetic shows up on the
  // channel that it hits rather than only on channel zero.
  generate
    for (c = 0; c < NCH; c++) begin : g_chk
      err_flag_a: assert property (
        err_evt[c]
        |=> s.flags[GRP*c+BIT_ERR] && s.flags[GRP*c+BIT_GLOB]
      ) else $error("error flag missed its event");

      half_flag_a: assert property (
        half_evt[c]
        |=> s.flags[GRP*c+BIT_HALF] && s.flags[GRP*c+BIT_GLOB]
      ) else $error("half flag missed its event");

      done_flag_a: assert property (
        done_evt[c]
        |=> s.flags[GRP*c+BIT_DONE] && s.flags[GRP*c+BIT_GLOB]
      ) else $error("complete flag missed its event");

      err_clear_a: assert property (
        s.dp_wr && s.dp_ofs == OFS_CLEAR && (hwdata[GRP*c+BIT_ERR] || hwdata[GRP*c+BIT_GLOB]) && !err_evt[c]
        |=> !s.flags[GRP*c+BIT_ERR]
      ) else $error("error flag survived its clear");

      half_clear_a: assert property (
        s.dp_wr && s.dp_ofs == OFS_CLEAR && (hwdata[GRP*c+BIT_HALF] || hwdata[GRP*c+BIT_GLOB]) && !half_evt[c]
        |=> !s.flags[GRP*c+BIT_HALF]
      ) else $error("half flag survived its clear");

      done_wipe_a: assert property (
        s.dp_wr && s.dp_ofs == OFS_CLEAR && (hwdata[GRP*c+BIT_DONE] || hwdata[GRP*c+BIT_GLOB]) && !done_evt[c]
        |=> !s.flags[GRP*c+BIT_DONE]
      ) else $error("complete flag survived its clear");

      group_wipe_a: assert property (
        s.dp_wr && s.dp_ofs == OFS_CLEAR && hwdata[GRP*c+BIT_GLOB] && set_v[GRP*c +: GRP] == 4'h0
        |=> s.flags[GRP*c +: GRP] == 4'h0
      ) else $error("global clear left a flag of the channel");

      zero_keep_a: assert property (
        s.dp_wr && s.dp_ofs == OFS_CLEAR && hwdata[GRP*c +: GRP] == 4'h0
        |=> (s.flags[GRP*c +: GRP] & $past(s.flags[GRP*c +: GRP])) == $past(s.flags[GRP*c +: GRP])
      ) else $error("zero clear bits dropped a flag");

      glob_fall_a: assert property (
        $fell(s.flags[GRP*c+BIT_GLOB])
        |-> s.flags[GRP*c+1 +: 3] == 3'h0
      ) else $error("global flag dropped while a flag is set");

      glob_rise_a: assert property (
        s.flags[GRP*c+1 +: 3] != 3'h0
        |-> s.flags[GRP*c+BIT_GLOB]
      ) else $error("global flag low while a flag is set");

      err_rise_a: assert property (
        $rose(s.flags[GRP*c+BIT_ERR])
        |-> $past(err_evt[c])
      ) else $error("error flag rose without an event");

      half_rise_a: assert property (
        $rose(s.flags[GRP*c+BIT_HALF])
        |-> $past(half_evt[c])
      ) else $error("half flag rose without an event");

      done_rise_a: assert property (
        $rose(s.flags[GRP*c+BIT_DONE])
        |-> $past(done_evt[c])
      ) else $error("complete flag rose without an event");

      trig_hit_a: assert property (
        err_evt[c] || half_evt[c] || done_evt[c]
        |=> chan_trig[c]
      ) else $error("channel trigger missing");

      trig_idle_a: assert property (
        !(err_evt[c] || half_evt[c] || done_evt[c])
        |=> !chan_trig[c]
      ) else $error("channel trigger without an event");

      irq_type_a: assert property (
        (s.flags[GRP*c+1 +: 3] & s.mask[GRP*c+1 +: 3]) != 3'h0
        |-> chan_irq[c]
      ) else $error("enabled flag gave no channel interrupt");

      irq_off_a: assert property (
        (s.flags[GRP*c+1 +: 3] & s.mask[GRP*c+1 +: 3]) == 3'h0
        |-> !chan_irq[c]
      ) else $error("channel interrupt without an enabled flag");

      err_event_a: assert property (
        err_evt[c]
        |=> s.evt[GRP*c+BIT_ERR] && s.evt[GRP*c+BIT_GLOB]
      ) else $error("error event not noted for interrupt");

      half_event_a: assert property (
        half_evt[c]
        |=> s.evt[GRP*c+BIT_HALF] && s.evt[GRP*c+BIT_GLOB]
      ) else $error("half event not noted for interrupt");

      done_event_a: assert property (
        done_evt[c]
        |=> s.evt[GRP*c+BIT_DONE] && s.evt[GRP*c+BIT_GLOB]
      ) else $error("complete event not noted for interrupt");
    end
  endgenerate

endmodule

// *** dcsf_top_tb.sv ***
`timescale 1ns/1ns
module dcsf_top_tb;
  import dcsf_pkg::*;
  logic        sys_clk   = 1'h0;
  logic        rstn      = 1'h0;
  logic        hsel      = 1'h0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'h0;
  logic [2:0]  hsize     = 3'h0;
  logic [31:0] hwdata    = 32'h0;
  logic [7:0]  err_evt   = 8'h0;
  logic [7:0]  half_evt  = 8'h0;
  logic [7:0]  done_evt  = 8'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  logic [7:0]  chan_irq;
  logic [7:0]  chan_trig;
  int          err_total = 0;
  int          checked   = 0;

  always #5 sys_clk = ~sys_clk;

  dcsf_top u_dcsf_top (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .err_evt(err_evt), .half_evt(half_evt),
    .done_evt(done_evt), .chan_irq(chan_irq), .chan_trig(chan_trig), .irq(irq));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task bus(input logic w, input logic [11:0] ofs, input logic [31:0] wd);
    hsel   <= 1'h1;
    haddr  <= BASE_ADDR + {20'h0, ofs};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task fire(input int ch, input int t);
    err_evt  <= (t == BIT_ERR) ? 8'h01 << ch : 8'h00;
    half_evt <= (t == BIT_HALF) ? 8'h01 << ch : 8'h00;
    done_evt <= (t == BIT_DONE) ? 8'h01 << ch : 8'h00;
    @(posedge sys_clk);
    err_evt  <= 8'h00;
    half_evt <= 8'h00;
    done_evt <= 8'h00;
    @(posedge sys_clk);
    chk({24'h0, chan_trig}, 32'h1 << ch);
  endtask

  task wrap_up;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    wrap_up;
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    chk({31'h0, hreadyout}, 32'h1);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, OFS_CLEAR, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, OFS_NONE, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int ch = 0; ch < NCH; ch++) begin
      for (int t = BIT_DONE; t <= BIT_ERR; t++) begin
        fire(ch, t);
        bus(1'h0, OFS_STATUS, 32'h0);
        chk(rd, (32'h1 << (4 * ch + t)) | (32'h1 << (4 * ch)));
        bus(1'h1, OFS_CLEAR, 32'h1 << (4 * ch + t));
        bus(1'h0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
      end
    end
    $display("test single flags done");
    for (int ch = 0; ch < NCH; ch++) begin
      for (int t = BIT_DONE; t <= BIT_ERR; t++) fire(ch, t);
      bus(1'h1, OFS_STATUS, 32'hffff_ffff);
      bus(1'h1, OFS_NONE, 32'hffff_ffff);
      bus(1'h1, OFS_CLEAR, 32'h0);
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rd, 32'hf << (4 * ch));
      bus(1'h1, OFS_CLEAR, 32'h1 << (4 * ch));
      bus(1'h0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0);
    end
    $display("test global clear done");
    bus(1'h0, OFS_EVENT, 32'h0);
    chk(rd, 32'hffff_ffff);
    bus(1'h1, OFS_MASK, 32'h8);
    bus(1'h0, OFS_MASK, 32'h0);
    chk(rd, 32'h8);
    fire(0, BIT_ERR);
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, chan_irq}, 32'h1);
    fire(1, BIT_ERR);
    bus(1'h0, OFS_EVENT, 32'h0);
    chk(rd, 32'h99);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    fire(2, BIT_HALF);
    chk({31'h0, irq}, 32'h0);
    chk({24'h0, chan_irq}, 32'h1);
    bus(1'h1, OFS_CLEAR, 32'hffff_ffff);
    @(posedge sys_clk);
    chk({24'h0, chan_irq}, 32'h0);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test interrupt done");
    fire(0, BIT_ERR);
    chk({31'h0, irq}, 32'h1);
    rstn <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    chk({24'h0, chan_irq}, 32'h0);
    bus(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, OFS_MASK, 32'h0);
    chk(rd, 32'h0);
    $display("test mid reset done");
    wrap_up;
  end
endmodule
